// >>> dv/scd_clkgen_model.sv
// clock generator model: clock presence and the two sampled sync-reference streams
`timescale 1ns/100ps
module scd_clkgen_model (
  input  wire logic ref_clk,
  output logic      clk_det_pin,
  output logic      sysref_rise_smp,
  output logic      sysref_fall_smp
);
  initial begin
    clk_det_pin = 1'b0;
    sysref_rise_smp = 1'b0;
    sysref_fall_smp = 1'b0;
  end
  // a narrow reference pulse may be caught by one sampling edge only, so each stream is set apart
  task automatic drive(input logic on_rise, input logic on_fall);
    @(negedge ref_clk);
    sysref_rise_smp = on_rise;
    sysref_fall_smp = on_fall;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic set_clk(input logic on);
    @(negedge ref_clk);
    clk_det_pin = on;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the clock delay and sync-reference capture block
`timescale 1ns/100ps
module tb_top;
  import scd_pkg::*;
  logic      ref_clk, rstn, spi_sclk, spi_csb_n, sdio_drv, sdio_out, sdio_oe;
  logic      clk_det_pin, rise_smp, fall_smp;
  logic      fine_dly_on, datapath_rst, sysref_capture, sysref_flag;
  scd_byte_t fine_skew, rd;
  scd_byte_t skew_in [5] = '{8'h60, 8'h57, 8'h10, 8'ha8, 8'h80};
  scd_byte_t skew_ex [5] = '{8'h57, 8'h57, 8'h10, 8'ha8, 8'ha8};
  int        n_fail = 0, comparisons = 0, n_cap = 0, n_rst = 0, cycles = 0;
  // the pin carries the block's data while it drives, the bench's otherwise
  wire logic sdio_in = sdio_oe ? sdio_out : sdio_drv;

  scd_clkgen_model u_gen (.ref_clk(ref_clk), .clk_det_pin(clk_det_pin),
    .sysref_rise_smp(rise_smp), .sysref_fall_smp(fall_smp));
  scd_clock_delay_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .clk_det_pin(clk_det_pin), .sysref_rise_smp(rise_smp), .sysref_fall_smp(fall_smp),
    .fine_skew(fine_skew), .fine_dly_on(fine_dly_on), .datapath_rst(datapath_rst),
    .sysref_capture(sysref_capture), .sysref_flag(sysref_flag));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // pulses are counted here so a one-cycle output is never missed
  always @(posedge ref_clk) begin
    cycles++;
    if (sysref_capture === 1'b1) n_cap++;
    if (datapath_rst === 1'b1) n_rst++;
    if (cycles == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one 24-bit frame; sclk phases of 8 cycles leave room for the sync delay
  task automatic xfer(input logic rw, input scd_addr_t a, input scd_byte_t d);
    logic [23:0] f;
    f = {rw, a, d};
    spi_csb_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      sdio_drv = f[23-i];
      repeat (8) @(negedge ref_clk);
      if (i >= 16) rd[23-i] = sdio_in;
      spi_sclk = 1'b1;
      repeat (8) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (8) @(negedge ref_clk);
    spi_csb_n = 1'b1;
    repeat (12) @(negedge ref_clk);
  endtask

  task automatic wr(input scd_addr_t a, input scd_byte_t d);
    xfer(1'b0, a, d);
  endtask

  task automatic rdchk(input string what, input scd_addr_t a, input scd_byte_t exp);
    xfer(1'b1, a, 8'h00);
    check(what, rd, exp);
  endtask

  task automatic pulse();
    u_gen.drive(1'b1, 1'b1);
    u_gen.drive(1'b0, 1'b0);
  endtask

  initial begin
    rstn = 1'b0;
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    sdio_drv = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    rdchk("dly_en", A_DLY_EN, RST_DLY_EN);
    rdchk("skew", A_SKEW, RST_SKEW);
    rdchk("ctl1", A_CTL1, RST_CTL1);
    rdchk("ctl2", A_CTL2, RST_CTL2);
    rdchk("unmapped", 15'h0122, 8'h00);
    u_gen.set_clk(1'b1);
    rdchk("clk_on", A_CLK_STS, 8'h01);
    u_gen.set_clk(1'b0);
    rdchk("clk_off", A_CLK_STS, 8'h00);
    wr(A_SKEW, 8'h60);
    check("skew_off", fine_skew, 8'h00);
    wr(A_DLY_EN, 8'h01);
    check("dp_rst", 8'(n_rst), 8'h01);
    check("dly_on", {7'h00, fine_dly_on}, 8'h01);
    wr(A_DLY_EN, 8'h01);
    check("dp_rst_again", 8'(n_rst), 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(A_SKEW, skew_in[k]);
      check("skew_clamp", fine_skew, skew_ex[k]);
    end
    rdchk("skew_rd", A_SKEW, 8'h80);
    wr(A_DLY_EN, 8'h00);
    check("skew_dis", fine_skew, 8'h00);
    wr(A_CTL1, 8'h00);
    n_cap = 0;
    pulse();
    check("mode_off", 8'(n_cap), 8'h00);
    wr(A_CTL1, 8'h02);
    n_cap = 0;
    u_gen.drive(1'b1, 1'b1);
    check("rise_trans", 8'(n_cap), 8'h01);
    u_gen.drive(1'b0, 1'b0);
    check("rise_only", 8'(n_cap), 8'h01);
    wr(A_CTL1, 8'h12);
    n_cap = 0;
    u_gen.drive(1'b1, 1'b1);
    check("fall_wait", 8'(n_cap), 8'h00);
    u_gen.drive(1'b0, 1'b0);
    check("fall_trans", 8'(n_cap), 8'h01);
    wr(A_CTL1, 8'h0a);
    n_cap = 0;
    u_gen.drive(1'b1, 1'b0);
    u_gen.drive(1'b0, 1'b0);
    check("edge_rise_ign", 8'(n_cap), 8'h00);
    u_gen.drive(1'b0, 1'b1);
    u_gen.drive(1'b0, 1'b0);
    check("edge_fall", 8'(n_cap), 8'h01);
    check("flag_set", {7'h00, sysref_flag}, 8'h01);
    wr(A_CTL1, 8'h4a);
    pulse();
    check("flag_held", {7'h00, sysref_flag}, 8'h00);
    wr(A_CTL2, 8'h02);
    wr(A_CTL1, 8'h04);
    n_cap = 0;
    repeat (2) pulse();
    check("nshot_skip", 8'(n_cap), 8'h00);
    pulse();
    check("nshot_cap", 8'(n_cap), 8'h01);
    repeat (2) pulse();
    check("nshot_stop", 8'(n_cap), 8'h01);
    wr(A_CTL2, 8'h00);
    n_cap = 0;
    repeat (2) pulse();
    check("nshot_rearm", 8'(n_cap), 8'h01);
    wr(A_CTL2, 8'hf5);
    rdchk("ctl2_mask", A_CTL2, 8'h05);
    wr(A_CTL1, 8'hff);
    rdchk("ctl1_mask", A_CTL1, 8'h5e);
    n_cap = 0;
    pulse();
    check("mode_rsvd", 8'(n_cap), 8'h00);
    // a second reset in mid-run must clear the written controls again
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    rdchk("ctl1_rst", A_CTL1, RST_CTL1);
    rdchk("ctl2_rst", A_CTL2, RST_CTL2);
    print_verdict();
  end
endmodule

// >>> pkg/scd_pkg.sv
// constants and types for the sample-clock delay and sync-reference capture block
package scd_pkg;
  typedef logic [14:0] scd_addr_t;
  typedef logic [7:0]  scd_byte_t;

  // register offsets
  localparam scd_addr_t A_DLY_EN  = 15'h0117;
  localparam scd_addr_t A_SKEW    = 15'h0118;
  localparam scd_addr_t A_CLK_STS = 15'h011c;
  localparam scd_addr_t A_CTL1    = 15'h0120;
  localparam scd_addr_t A_CTL2    = 15'h0121;

  // reset values
  localparam scd_byte_t RST_DLY_EN = 8'h00;
  localparam scd_byte_t RST_SKEW   = 8'h00;
  localparam scd_byte_t RST_CTL1   = 8'h00;
  localparam scd_byte_t RST_CTL2   = 8'h00;

  // field positions and masks
  localparam int        B_DLY_EN    = 0;
  localparam int        B_CLK_DET   = 0;
  localparam int        B_FLAG_RST  = 6;
  localparam int        B_TRANS_SEL = 4;
  localparam int        B_EDGE_SEL  = 3;
  localparam int        B_MODE_LO   = 1;
  localparam scd_byte_t CTL1_MASK   = 8'h5e;
  localparam scd_byte_t CTL2_MASK   = 8'h0f;

  // capture mode codes
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_CONT  = 2'h1;
  localparam logic [1:0] MODE_NSHOT = 2'h2;

  // skew end codes
  localparam scd_byte_t SKEW_MAX = 8'h57;
  localparam scd_byte_t SKEW_MIN = 8'ha8;

  // serial frame: r/w bit, 15 address bits, 8 data bits
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT   = 5'h17;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  typedef enum logic [2:0] {
    CAP_OFF   = 3'h1,
    CAP_ARMED = 3'h2,
    CAP_DONE  = 3'h4
  } scd_cap_e;
endpackage

// >>> verilog/scd_clock_delay_ctrl.sv
// clock fine-delay and sync-reference capture control with serial register port
`timescale 1ns/100ps
module scd_clock_delay_ctrl (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          spi_sclk,
  input  wire logic          spi_csb_n,
  input  wire logic          sdio_in,
  output logic               sdio_out,
  output logic               sdio_oe,
  input  wire logic          clk_det_pin,
  input  wire logic          sysref_rise_smp,
  input  wire logic          sysref_fall_smp,
  output scd_pkg::scd_byte_t fine_skew,
  output logic               fine_dly_on,
  output logic               datapath_rst,
  output logic               sysref_capture,
  output logic               sysref_flag
);
  import scd_pkg::*;

  function automatic logic hit(input scd_addr_t a, input scd_addr_t o);
    hit = (a == o);
  endfunction

  logic       wr_en;
  scd_addr_t  addr;
  scd_byte_t  wr_data;
  scd_byte_t  rd_data;
  logic       dly_en;
  scd_byte_t  skew;
  scd_byte_t  ctl1;
  logic [3:0] ign;
  logic [3:0] skip;
  logic [2:0] s1;
  logic [2:0] s2;
  logic       smp_d;
  scd_cap_e   cap_st;
  scd_cap_e   next_cap_st;

  scd_serial_port u_port (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .spi_sclk  (spi_sclk),
    .spi_csb_n (spi_csb_n),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe   (sdio_oe),
    .wr_en     (wr_en),
    .addr      (addr),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  wire wr_dly  = wr_en && hit(addr, A_DLY_EN);
  wire wr_skew = wr_en && hit(addr, A_SKEW);
  wire wr_ctl1 = wr_en && hit(addr, A_CTL1);
  wire wr_ctl2 = wr_en && hit(addr, A_CTL2);
  wire rearm   = wr_ctl1 || wr_ctl2;

  wire clk_det   = s2[2];
  wire flag_rst  = ctl1[B_FLAG_RST];
  wire trans_sel = ctl1[B_TRANS_SEL];
  wire edge_sel  = ctl1[B_EDGE_SEL];
  wire [1:0] mode = ctl1[B_MODE_LO +: 2];

  // register reads; unmapped and reserved bits read zero
  assign rd_data = hit(addr, A_DLY_EN)  ? {7'h00, dly_en} :
                   hit(addr, A_SKEW)    ? skew :
                   hit(addr, A_CLK_STS) ? {7'h00, clk_det} :
                   hit(addr, A_CTL1)    ? ctl1 :
                   hit(addr, A_CTL2)    ? {4'h0, ign} : 8'h00;

  // fine delay: clamp to the end codes, zero skew while disabled
  wire skew_hi = $signed(skew) >= $signed(SKEW_MAX);
  wire skew_lo = $signed(skew) <= $signed(SKEW_MIN);
  wire [7:0] clamp = skew_hi ? SKEW_MAX : skew_lo ? SKEW_MIN : skew;
  wire [7:0] next_fine_skew = dly_en ? clamp : 8'h00;
  wire next_dp_rst = wr_dly && wr_data[B_DLY_EN] && !dly_en;

  // sampled edge chosen first, then transition polarity on the chosen stream
  wire smp     = edge_sel ? s2[0] : s2[1];
  wire rise_ev = smp & ~smp_d;
  wire fall_ev = ~smp & smp_d;
  wire evt     = trans_sel ? fall_ev : rise_ev;
  wire shot_ok = (cap_st == CAP_ARMED) && (skip == ign);
  wire next_cap = evt && ((mode == MODE_CONT) ||
                          (mode == MODE_NSHOT && shot_ok));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dly_en <= RST_DLY_EN[B_DLY_EN];
      skew <= RST_SKEW;
      ctl1 <= RST_CTL1;
      ign <= RST_CTL2[3:0];
    end else begin
      if (wr_dly) dly_en <= wr_data[B_DLY_EN];
      if (wr_skew) skew <= wr_data;
      if (wr_ctl1) ctl1 <= wr_data & CTL1_MASK;
      if (wr_ctl2) ign <= wr_data[3:0] & CTL2_MASK[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fine_skew <= 8'h00;
      fine_dly_on <= 1'b0;
      datapath_rst <= 1'b0;
    end else begin
      fine_skew <= next_fine_skew;
      fine_dly_on <= dly_en;
      datapath_rst <= next_dp_rst;
    end
  end

  // samples and clock detect come from pin capture: two flops first
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      smp_d <= 1'b0;
    end else begin
      s1 <= {clk_det_pin, sysref_rise_smp, sysref_fall_smp};
      s2 <= s1;
      smp_d <= smp;
    end
  end

  // any ctl1 or ctl2 write drops to off so a new N-shot starts with a fresh skip count
  always_comb begin
    next_cap_st = cap_st;
    case (cap_st)
      CAP_OFF:   if (mode == MODE_NSHOT) next_cap_st = CAP_ARMED;
      CAP_ARMED: begin
        if (mode != MODE_NSHOT) next_cap_st = CAP_OFF;
        else if (evt && skip == ign) next_cap_st = CAP_DONE;
      end
      CAP_DONE:  if (mode != MODE_NSHOT) next_cap_st = CAP_OFF;
      default:   next_cap_st = CAP_OFF;
    endcase
    if (rearm) next_cap_st = CAP_OFF;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cap_st <= CAP_OFF;
      skip <= 4'h0;
      sysref_capture <= 1'b0;
      sysref_flag <= 1'b0;
    end else begin
      cap_st <= next_cap_st;
      if (cap_st != CAP_ARMED) skip <= 4'h0;
      else if (evt && skip != ign) skip <= skip + 4'h1;
      sysref_capture <= next_cap;
      // the held reset wins over event sets
      sysref_flag <= flag_rst ? 1'b0 : (sysref_flag | next_cap);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_skew_off_zero: assert property (!dly_en |=> fine_skew == 8'h00)
    else $error("skew applied while fine delay disabled");
  a_skew_hi_sat: assert property (dly_en && $signed(skew) >= 87
      |=> fine_skew == 8'h57)
    else $error("skew not saturated at top end code");
  a_skew_lo_sat: assert property (dly_en && $signed(skew) <= -88
      |=> fine_skew == 8'ha8)
    else $error("skew not saturated at bottom end code");
  a_dp_rst_pulse: assert property (wr_dly && wr_data[0] && !dly_en
      |=> datapath_rst ##1 !datapath_rst)
    else $error("datapath reset not pulsed on enable");
  a_dp_rst_cause: assert property (datapath_rst
      |-> $past(wr_dly) && !$past(dly_en))
    else $error("datapath reset without an enabling write");
  a_dly_on_follow: assert property (##1 fine_dly_on == $past(dly_en))
    else $error("fine delay enable output does not follow register");
  a_clk_det_sync: assert property (##2 clk_det == $past(clk_det_pin, 2))
    else $error("clock detect status does not follow pin");
  a_flag_held: assert property (flag_rst |=> !sysref_flag)
    else $error("flag set while held in reset");
  a_flag_set: assert property (sysref_capture && !$past(flag_rst)
      |-> sysref_flag)
    else $error("capture did not set the flag");
  a_cap_disabled: assert property (mode == MODE_OFF && !rearm |=> !sysref_capture)
    else $error("capture while mode disabled");
  a_mode_res_off: assert property (mode == 2'h3 |=> !sysref_capture)
    else $error("capture in the unused mode code");
  a_cont_rise_cap: assert property (mode == MODE_CONT && !trans_sel && !edge_sel
      && s2[1] && !smp_d |=> sysref_capture)
    else $error("rising-edge low-to-high event not captured");
  a_cont_fall_cap: assert property (mode == MODE_CONT && trans_sel && edge_sel
      && !s2[0] && smp_d |=> sysref_capture)
    else $error("falling-edge high-to-low event not captured");
  a_nshot_single: assert property (sysref_capture && mode == MODE_NSHOT
      && !$past(rearm) |-> cap_st == CAP_DONE ##1 (!sysref_capture [*2]))
    else $error("N-shot captured more than once");
  a_shot_done_quiet: assert property (cap_st == CAP_DONE && mode == MODE_NSHOT
      |=> !sysref_capture)
    else $error("capture after the single N-shot event");
  a_nshot_skip: assert property (cap_st == CAP_ARMED && evt && skip != ign
      && !rearm |=> !sysref_capture && skip == $past(skip) + 4'h1)
    else $error("ignored event not counted");
  a_reset_zero: assert property ($rose(rstn) |-> ctl1 == 8'h00 && ign == 4'h0
      && skew == 8'h00 && !dly_en)
    else $error("control registers not zero after reset");
endmodule

// >>> verilog/scd_serial_port.sv
// serial register port slave, oversampled on the device clock
`timescale 1ns/100ps
module scd_serial_port (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             spi_sclk,
  input  wire logic             spi_csb_n,
  input  wire logic             sdio_in,
  output logic                  sdio_out,
  output logic                  sdio_oe,
  output logic                  wr_en,
  output scd_pkg::scd_addr_t    addr,
  output scd_pkg::scd_byte_t    wr_data,
  input  wire scd_pkg::scd_byte_t rd_data
);
  import scd_pkg::*;

  logic [2:0] s1;
  logic [2:0] s2;
  logic       sclk_d;
  logic [4:0] cnt;
  logic [15:0] instr;
  logic [6:0] din_sh;
  logic [7:0] dout;

  // pins come from another domain: two flops before any use
  wire sck  = s2[2];
  wire csn  = s2[1];
  wire din  = s2[0];
  wire rise = sck & ~sclk_d & ~csn;
  wire fall = ~sck & sclk_d & ~csn;
  wire in_instr = cnt < INSTR_BITS;
  wire next_wr  = rise && (cnt == LAST_BIT) && !instr[15];

  assign addr     = instr[14:0];
  assign sdio_out = dout[7];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      // idle pin levels (sclk low, csb high) so no false edge or select follows reset
      s1 <= 3'h2;
      s2 <= 3'h2;
      sclk_d <= 1'b0;
    end else begin
      s1 <= {spi_sclk, spi_csb_n, sdio_in};
      s2 <= s1;
      sclk_d <= s2[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || csn) begin
      cnt <= 5'h00;
    end else if (rise && cnt != FRAME_BITS) begin
      cnt <= cnt + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      instr <= 16'h0000;
      din_sh <= 7'h00;
    end else if (rise && in_instr) begin
      instr <= {instr[14:0], din};
    end else if (rise) begin
      din_sh <= {din_sh[5:0], din};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= next_wr;
      if (next_wr) begin
        wr_data <= {din_sh, din};
      end
    end
  end

  // read data leaves on falling sclk so the master samples it on the rise
  always_ff @(posedge ref_clk) begin
    if (!rstn || csn) begin
      dout <= 8'h00;
      sdio_oe <= 1'b0;
    end else if (fall && cnt == INSTR_BITS && instr[15]) begin
      dout <= rd_data;
      sdio_oe <= 1'b1;
    end else if (fall && cnt > INSTR_BITS) begin
      dout <= {dout[6:0], 1'b0};
    end
  end
endmodule
